// ### bench/mmc_regs_tb.sv
`timescale 1ns/1ns
module mmc_regs_tb;
   logic        clk   = 1'b0;
   logic        rst   = 1'b1;
   logic [4:0]  adr   = 5'h00;
   logic        rd    = 1'b0;
   logic        wr    = 1'b0;
   logic [31:0] wdat  = 32'h0;
   logic [3:0]  be    = 4'hf;
   logic [2:0]  mode  = 3'h0;
   logic [2:0]  code  = 3'h0;
   logic        ereq  = 1'b0;
   logic [15:0] caddr = 16'h0000;
   logic [31:0] rdat;
   logic        wreq;
   logic [1:0]  strch;
   logic        ewait;
   logic        fmap;
   logic        flow;
   logic [5:0]  pidx;
   logic [15:0] rbase;
   logic [15:0] rtop;
   int          mismatches = 0;
   int          checked    = 0;

   always #5 clk = ~clk;

   // The switch strap inputs all follow one code so that every size encoding is reached.
   mmc_regs mmc_regs_inst (
      .sys_clk_i(clk), .reset_i(rst), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .mode_i(mode),
      .register_space_switch_i(code[0]), .eeprom_space_switches_i(code[1:0]),
      .ram_space_switches_i(code), .flash_space_switches_i(~code[1:0]),
      .paging_split_switches_i(code[2:1]), .ext_req_i(ereq), .cpu_addr_i(caddr),
      .stretch_o(strch), .ext_wait_o(ewait), .flash_in_map_o(fmap),
      .flash_lower_sel_o(flow), .page_index_bits_o(pidx), .ram_base_o(rbase),
      .ram_top_o(rtop));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic do_reset(input logic [2:0] m, input logic [2:0] c);
      @(posedge clk);
      rst  <= 1'b1;
      mode <= m;
      code <= c;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   // The request is held until waitrequest is sampled low; data is taken at that edge.
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] b, output logic [7:0] q);
      int n;
      @(posedge clk);
      adr  <= a;
      wdat <= {24'h0, d};
      be   <= b;
      wr   <= w;
      rd   <= ~w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      q = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
      check({31'h0, wreq}, 32'h0, "waitrequest never fell");
   endtask

   task automatic wr8(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, 4'h1, q);
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [7:0] exp, input string what);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, 4'hf, q);
      check({24'h0, q}, {24'h0, exp}, what);
   endtask

   task automatic stretch_cnt(input int exp_n);
      int n;
      @(posedge clk);
      ereq <= 1'b1;
      @(posedge clk);
      ereq <= 1'b0;
      n = 0;
      repeat (8) begin
         @(posedge clk);
         if (ewait === 1'b1) n++;
      end
      check(n, exp_n, "stretch clocks");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_single();
      logic [7:0] q;
      do_reset(mmc_pkg::MMC_MODE_SINGLE, 3'h4);
      rdchk(mmc_pkg::OFF_MISC, {4'h0, mmc_pkg::RST_STRETCH, mmc_pkg::RST_UPPER, 1'b1}, "misc rst");
      rdchk(mmc_pkg::OFF_PAGE, mmc_pkg::RST_PAGE_ANY, "page rst");
      rdchk(mmc_pkg::OFF_TEST1, 8'h00, "test1 rst");
      rdchk(5'h1c, 8'h00, "unmapped");
      check({30'h0, strch}, 32'h0, "stretch single");
      stretch_cnt(0);
      check({31'h0, fmap}, 32'h1, "flash on");
      wr8(mmc_pkg::OFF_MISC, 8'hf0);
      repeat (3) @(posedge clk);
      rdchk(mmc_pkg::OFF_MISC, 8'h00, "misc first write");
      check({31'h0, fmap}, 32'h0, "flash off");
      wr8(mmc_pkg::OFF_MISC, 8'h0f);
      repeat (3) @(posedge clk);
      rdchk(mmc_pkg::OFF_MISC, 8'h00, "misc second write");
      check({31'h0, fmap}, 32'h0, "flash still off");
      wr8(mmc_pkg::OFF_TEST0, 8'hff);
      wr8(mmc_pkg::OFF_MEMORY_SIZE_0, 8'h00);
      wr8(mmc_pkg::OFF_MEMORY_SIZE_1, 8'hff);
      rdchk(mmc_pkg::OFF_TEST0, 8'h00, "test0 write");
      rdchk(mmc_pkg::OFF_MEMORY_SIZE_0, 8'h04, "size0 write");
      rdchk(mmc_pkg::OFF_MEMORY_SIZE_1, 8'hc2, "size1 write");
      wr8(mmc_pkg::OFF_PAGE, 8'hea);
      repeat (3) @(posedge clk);
      rdchk(mmc_pkg::OFF_PAGE, 8'h2a, "page write");
      check({26'h0, pidx}, 32'h2a, "page bits");
      bus(1'b1, mmc_pkg::OFF_PAGE, 8'h15, 4'h0, q);
      repeat (3) @(posedge clk);
      check({26'h0, pidx}, 32'h2a, "page no byte enable");
   endtask

   // Every strap code with both RAM alignments; the window top is taken as inclusive.
   task automatic t_sizes();
      logic [15:0] hi [8];
      logic [15:0] sz;
      hi = '{16'h0800, 16'h0000, 16'h0800, 16'h0000, 16'h1800, 16'h1000, 16'h0800, 16'h0000};
      for (int c = 0; c < 8; c++) begin
         do_reset(mmc_pkg::MMC_MODE_SINGLE, c[2:0]);
         sz = 16'((c + 1) * 16'h0800);
         rdchk(mmc_pkg::OFF_MEMORY_SIZE_0, {c[0], 1'b0, c[1:0], 1'b0, c[2:0]}, "size0");
         rdchk(mmc_pkg::OFF_MEMORY_SIZE_1, {~c[1:0], 4'h0, c[2:1]}, "size1");
         check({16'h0, rbase}, {16'h0, hi[c]}, "ram base high");
         check({16'h0, rtop}, {16'h0, hi[c] + sz - 16'h1}, "ram top high");
         wr8(mmc_pkg::OFF_ALIGN, 8'h00);
         repeat (3) @(posedge clk);
         check({16'h0, rbase}, (c == 0) ? 32'h0800 : 32'h0, "ram base low");
      end
   endtask

   task automatic t_expanded();
      do_reset(mmc_pkg::MMC_MODE_EXPANDED, 3'h7);
      rdchk(mmc_pkg::OFF_MISC, 8'h0d, "misc rst expanded");
      stretch_cnt(3);
      wr8(mmc_pkg::OFF_MISC, 8'h05);
      #1;
      check({30'h0, strch}, 32'h3, "stretch too early");
      repeat (3) @(posedge clk);
      check({30'h0, strch}, 32'h1, "stretch applied");
      stretch_cnt(1);
      wr8(mmc_pkg::OFF_MISC, 8'h0b);
      repeat (3) @(posedge clk);
      rdchk(mmc_pkg::OFF_MISC, 8'h05, "misc locked");
   endtask

   task automatic t_special();
      do_reset(mmc_pkg::MMC_MODE_SPECIAL_TEST, 3'h7);
      rdchk(mmc_pkg::OFF_MISC, 8'h0c, "misc rst special");
      for (int s = 0; s < 4; s++) begin
         wr8(mmc_pkg::OFF_MISC, {4'h0, s[1:0], 2'b01});
         repeat (3) @(posedge clk);
         rdchk(mmc_pkg::OFF_MISC, {4'h0, s[1:0], 2'b01}, "misc rewrite");
         stretch_cnt(s);
      end
      caddr <= 16'h4000;
      wr8(mmc_pkg::OFF_MISC, 8'h03);
      repeat (3) @(posedge clk);
      check({31'h0, flow}, 32'h0, "lower blocked");
      wr8(mmc_pkg::OFF_MISC, 8'h01);
      repeat (3) @(posedge clk);
      check({31'h0, flow}, 32'h1, "lower open");
      caddr <= 16'h9000;
      repeat (3) @(posedge clk);
      check({31'h0, flow}, 32'h0, "upper half");
   endtask

   task automatic t_periph();
      do_reset(mmc_pkg::MMC_MODE_PERIPH, 3'h2);
      rdchk(mmc_pkg::OFF_MISC, 8'h0d, "misc rst periph");
      check({30'h0, strch}, 32'h0, "stretch periph");
      stretch_cnt(0);
      do_reset(mmc_pkg::MMC_MODE_SPECIAL_SINGLE, 3'h1);
      rdchk(mmc_pkg::OFF_MISC, 8'h0d, "misc rst special single");
      check({30'h0, strch}, 32'h0, "stretch special single");
      stretch_cnt(0);
      wr8(mmc_pkg::OFF_MISC, 8'h08);
      repeat (3) @(posedge clk);
      wr8(mmc_pkg::OFF_MISC, 8'h04);
      repeat (3) @(posedge clk);
      rdchk(mmc_pkg::OFF_MISC, 8'h04, "special single rewrite");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      t_single();
      t_sizes();
      t_expanded();
      t_special();
      t_periph();
      close_out();
   end
endmodule

// ### verilog/mmc_once_field.sv
`timescale 1ns/1ns
// A write-once field: accepts one write after reset unless special mode.
module mmc_once_field #(
   parameter int W = 2
) (
   input  wire logic         sys_clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] reset_val_i,
   input  wire logic         special_i,
   input  wire logic         wr_i,
   input  wire logic [W-1:0] wdata_i,
   output logic      [W-1:0] value_o,
   output logic              locked_o
);
   if (W < 1) begin : g_bad_width
      $error("W must be positive.");
   end

   logic [W-1:0] value_r;
   logic         written_r;
   logic         seeded_r;

   // Reset value is loaded by a clocked process since it comes from a port.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         seeded_r <= 1'b0;
      end else begin
         seeded_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         value_r   <= '0;
         written_r <= 1'b0;
      end else if (!seeded_r) begin
         value_r <= reset_val_i;
      end else if (wr_i && (special_i || !written_r)) begin
         value_r   <= wdata_i;
         written_r <= 1'b1;
      end
   end

   assign value_o  = value_r;
   assign locked_o = written_r && !special_i;

   AST_ONCE_LOCK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      seeded_r && locked_o && !special_i |=> $stable(value_r))
      else $error("Write-once field changed after lock.");
endmodule

// ### verilog/mmc_pkg.sv
package mmc_pkg;

   // Register byte offsets on the Avalon-MM bus (word aligned).
   localparam logic [4:0] OFF_MISC     = 5'h00;
   localparam logic [4:0] OFF_TEST0    = 5'h04;
   localparam logic [4:0] OFF_TEST1    = 5'h08;
   localparam logic [4:0] OFF_MEMORY_SIZE_0  = 5'h0c;
   localparam logic [4:0] OFF_MEMORY_SIZE_1  = 5'h10;
   localparam logic [4:0] OFF_PAGE     = 5'h14;
   localparam logic [4:0] OFF_ALIGN    = 5'h18;

   // Control register field positions.
   localparam int MISC_STRETCH_LSB = 2;
   localparam int MISC_UPPER_BIT   = 1;
   localparam int MISC_FLASH_BIT   = 0;

   // Memory size register 0 field positions.
   localparam int MS0_REG_BIT      = 7;
   localparam int MS0_EEP_LSB      = 4;
   localparam int MS0_RAM_LSB      = 0;

   // Memory size register 1 field positions.
   localparam int MS1_FLASH_LSB    = 6;
   localparam int MS1_PAG_LSB      = 0;

   // Reset values.
   localparam logic [1:0] RST_STRETCH   = 2'h3;
   localparam logic       RST_UPPER     = 1'b0;
   localparam logic [7:0] RST_PAGE_ANY  = 8'h00;
   localparam logic [7:0] RST_PAGE_SPEC = 8'h3c;
   localparam logic [7:0] RST_RAM_POS   = 8'h09;
   localparam logic [7:0] TEST_READ_VAL = 8'h00;

   // Pending-write delay: one bus cycle after the write completes.
   localparam int APPLY_DELAY      = 1;

   typedef enum logic [2:0] {
      MMC_MODE_SINGLE,
      MMC_MODE_EXPANDED,
      MMC_MODE_PERIPH,
      MMC_MODE_EMUL,
      MMC_MODE_SPECIAL_SINGLE,
      MMC_MODE_SPECIAL_TEST
   } mmc_mode_e;

   typedef enum logic [1:0] {
      MMC_BUS_IDLE,
      MMC_BUS_ANSWER
   } mmc_bus_state_e;

endpackage

// ### verilog/mmc_regs.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
module mmc_regs #(
   parameter logic PAGE_SPECIAL_ONLY = 1'b0,
   parameter logic FLASH_RST_EXPANDED = 1'b1
) (
   input  wire logic                  sys_clk_i,
   input  wire logic                  reset_i,
   input  wire logic [4:0]            avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [31:0]           avs_writedata_i,
   input  wire logic [3:0]            avs_byteenable_i,
   output logic      [31:0]           avs_readdata_o,
   output logic                       avs_waitrequest_o,
   input  wire logic [2:0]            mode_i,
   input  wire logic                  register_space_switch_i,
   input  wire logic [1:0]            eeprom_space_switches_i,
   input  wire logic [2:0]            ram_space_switches_i,
   input  wire logic [1:0]            flash_space_switches_i,
   input  wire logic [1:0]            paging_split_switches_i,
   input  wire logic                  ext_req_i,
   input  wire logic [15:0]           cpu_addr_i,
   output logic      [1:0]            stretch_o,
   output logic                       ext_wait_o,
   output logic                       flash_in_map_o,
   output logic                       flash_lower_sel_o,
   output logic      [5:0]            page_index_bits_o,
   output logic      [15:0]           ram_base_o,
   output logic      [15:0]           ram_top_o
);

   if ($bits(mode_i) != 3) begin : g_bad_mode
      $error("Mode input must be three bits.");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers for mode and switch straps.

   logic [12:0] strap_meta_r;
   logic [12:0] strap_r;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         strap_meta_r <= '0;
         strap_r      <= '0;
      end else begin
         strap_meta_r <= {mode_i, register_space_switch_i, eeprom_space_switches_i,
                          ram_space_switches_i, flash_space_switches_i,
                          paging_split_switches_i};
         strap_r      <= strap_meta_r;
      end
   end

   logic [2:0] mode_s;
   logic       reg_sw_s;
   logic [1:0] eeprom_space_switches_s;
   logic [2:0] ram_space_switches_s;
   logic [1:0] flash_sw_s;
   logic [1:0] paging_split_switches_s;

   assign {mode_s, reg_sw_s, eeprom_space_switches_s, ram_space_switches_s, flash_sw_s, paging_split_switches_s} = strap_r;

   function automatic logic is_special(input logic [2:0] m);
      return m == mmc_pkg::MMC_MODE_SPECIAL_SINGLE || m == mmc_pkg::MMC_MODE_SPECIAL_TEST;
   endfunction

   function automatic logic no_ext(input logic [2:0] m);
      return m == mmc_pkg::MMC_MODE_SINGLE || m == mmc_pkg::MMC_MODE_PERIPH
          || m == mmc_pkg::MMC_MODE_SPECIAL_SINGLE;
   endfunction

   logic special_s;
   assign special_s = is_special(mode_s);

   // The strap view needs two edges after reset to settle; reset values that
   // depend on mode are taken from the settled view.
   logic [1:0] settle_r;
   logic       settled;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         settle_r <= 2'h0;
      end else if (settle_r != 2'h3) begin
         settle_r <= settle_r + 2'h1;
      end
   end

   assign settled = (settle_r == 2'h3);

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait state on every access, answer in the second cycle.

   mmc_pkg::mmc_bus_state_e bus_state_r;
   logic                    bus_req;
   logic                    wr_fire;
   logic                    wait_r;

   assign bus_req = (avs_read_i || avs_write_i) && settled;
   assign wr_fire = avs_write_i && bus_state_r == mmc_pkg::MMC_BUS_ANSWER
                    && avs_byteenable_i[0];

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         bus_state_r <= mmc_pkg::MMC_BUS_IDLE;
         wait_r      <= 1'b1;
      end else begin
         unique case (bus_state_r)
            mmc_pkg::MMC_BUS_IDLE: begin
               if (bus_req) begin
                  bus_state_r <= mmc_pkg::MMC_BUS_ANSWER;
                  wait_r      <= 1'b0;
               end
            end
            mmc_pkg::MMC_BUS_ANSWER: begin
               bus_state_r <= mmc_pkg::MMC_BUS_IDLE;
               wait_r      <= 1'b1;
            end
            default: begin
               bus_state_r <= mmc_pkg::MMC_BUS_IDLE;
               wait_r      <= 1'b1;
            end
         endcase
      end
   end

   // Waitrequest comes from its own flop so that the bus sees no decode glitch.
   assign avs_waitrequest_o = wait_r;

   ////////////////////////////////////////////////////////////////////////////
   // Control register: staged writes, write-once fields.

   logic       wr_misc;
   logic [1:0] stretch_stage;
   logic       upper_stage;
   logic       flash_stage;
   logic       flash_rst;

   assign wr_misc = wr_fire && avs_address_i == mmc_pkg::OFF_MISC;

   always_comb begin
      unique case (mode_s)
         mmc_pkg::MMC_MODE_EXPANDED,
         mmc_pkg::MMC_MODE_EMUL:         flash_rst = FLASH_RST_EXPANDED;
         mmc_pkg::MMC_MODE_SPECIAL_TEST: flash_rst = 1'b0;
         default:                        flash_rst = 1'b1;
      endcase
   end

   mmc_once_field #(.W(2)) u_stretch_field (
      .sys_clk_i   (sys_clk_i),
      .reset_i     (reset_i || !settled),
      .reset_val_i (mmc_pkg::RST_STRETCH),
      .special_i   (special_s),
      .wr_i        (wr_misc),
      .wdata_i     (avs_writedata_i[mmc_pkg::MISC_STRETCH_LSB +: 2]),
      .value_o     (stretch_stage),
      .locked_o    ()
   );

   mmc_once_field #(.W(1)) u_upper_field (
      .sys_clk_i   (sys_clk_i),
      .reset_i     (reset_i || !settled),
      .reset_val_i (mmc_pkg::RST_UPPER),
      .special_i   (special_s),
      .wr_i        (wr_misc),
      .wdata_i     (avs_writedata_i[mmc_pkg::MISC_UPPER_BIT]),
      .value_o     (upper_stage),
      .locked_o    ()
   );

   mmc_once_field #(.W(1)) u_flash_field (
      .sys_clk_i   (sys_clk_i),
      .reset_i     (reset_i || !settled),
      .reset_val_i (flash_rst),
      .special_i   (special_s),
      .wr_i        (wr_misc),
      .wdata_i     (avs_writedata_i[mmc_pkg::MISC_FLASH_BIT]),
      .value_o     (flash_stage),
      .locked_o    ()
   );

   // The staged value reaches the map one clock after the write completes, so
   // the access in flight is decoded with the old mapping.
   logic [1:0] stretch_r;
   logic       upper_r;
   logic       flash_r;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         stretch_r <= mmc_pkg::RST_STRETCH;
         upper_r   <= mmc_pkg::RST_UPPER;
         flash_r   <= 1'b0;
      end else begin
         stretch_r <= stretch_stage;
         upper_r   <= upper_stage;
         flash_r   <= flash_stage;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page index and RAM alignment registers.

   logic [5:0] page_r;
   logic       align_r;
   logic       page_ok;

   assign page_ok = !PAGE_SPECIAL_ONLY || special_s;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i || !settled) begin
         page_r <= PAGE_SPECIAL_ONLY ? mmc_pkg::RST_PAGE_SPEC[5:0]
                                     : mmc_pkg::RST_PAGE_ANY[5:0];
      end else if (wr_fire && avs_address_i == mmc_pkg::OFF_PAGE && page_ok) begin
         page_r <= avs_writedata_i[5:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         align_r <= mmc_pkg::RST_RAM_POS[0];
      end else if (wr_fire && avs_address_i == mmc_pkg::OFF_ALIGN) begin
         align_r <= avs_writedata_i[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Size views, RAM placement and read mux.

   logic [7:0]  size0;
   logic [7:0]  size1;
   logic [15:0] region;
   logic [15:0] ram_len;
   logic [15:0] region_base;

   assign size0 = {reg_sw_s, 1'b0, eeprom_space_switches_s, 1'b0, ram_space_switches_s};
   assign size1 = {flash_sw_s, 4'h0, paging_split_switches_s};

   always_comb begin
      ram_len = {2'h0, ram_space_switches_s, 11'h0} + 16'h0800;
      unique case (ram_space_switches_s)
         3'h0:                   region = 16'h0800;
         3'h1:                   region = 16'h1000;
         3'h2, 3'h3:             region = 16'h2000;
         default:                region = 16'h4000;
      endcase
      region_base = {mmc_pkg::RST_RAM_POS[7:3], 11'h0} & ~(region - 16'h1);
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ram_base_o <= 16'h0;
         ram_top_o  <= 16'h0;
      end else if (align_r) begin
         ram_base_o <= region_base + region - ram_len;
         ram_top_o  <= region_base + region - 16'h1;
      end else begin
         ram_base_o <= region_base;
         ram_top_o  <= region_base + ram_len - 16'h1;
      end
   end

   logic [7:0] rd_byte;

   always_comb begin
      unique case (avs_address_i)
         mmc_pkg::OFF_MISC:    rd_byte = {4'h0, stretch_r, upper_r, flash_r};
         mmc_pkg::OFF_TEST0,
         mmc_pkg::OFF_TEST1:   rd_byte = mmc_pkg::TEST_READ_VAL;
         mmc_pkg::OFF_MEMORY_SIZE_0: rd_byte = size0;
         mmc_pkg::OFF_MEMORY_SIZE_1: rd_byte = size1;
         mmc_pkg::OFF_PAGE:    rd_byte = {2'h0, page_r};
         mmc_pkg::OFF_ALIGN:   rd_byte = {7'h0, align_r};
         default:              rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i && bus_state_r == mmc_pkg::MMC_BUS_IDLE && bus_req) begin
         avs_readdata_o <= {24'h0, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Map outputs.

   logic stretch_en;
   assign stretch_en = !no_ext(mode_s);

   mmc_stretch u_stretch (
      .sys_clk_i    (sys_clk_i),
      .reset_i      (reset_i),
      .ext_req_i    (ext_req_i),
      .stretch_i    (stretch_r),
      .stretch_en_i (stretch_en),
      .ext_wait_o   (ext_wait_o)
   );

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         stretch_o         <= 2'h0;
         flash_in_map_o    <= 1'b0;
         flash_lower_sel_o <= 1'b0;
         page_index_bits_o <= 6'h0;
      end else begin
         stretch_o         <= stretch_en ? stretch_r : 2'h0;
         flash_in_map_o    <= flash_r;
         flash_lower_sel_o <= flash_r && !upper_r && !cpu_addr_i[15];
         page_index_bits_o <= page_r;
      end
   end

   AST_MISC_DELAY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      settled && $changed(stretch_stage) |=> stretch_r == $past(stretch_stage))
      else $error("Control write not applied one cycle later.");
   AST_UPPER_BLOCK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      upper_r |=> !flash_lower_sel_o)
      else $error("Lower flash selected with upper-half bit set.");
   AST_FLASH_OFF: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !flash_r |=> !flash_in_map_o && !flash_lower_sel_o)
      else $error("Flash present while disabled.");
   AST_TEST_NOEFF: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      wr_fire && avs_address_i == mmc_pkg::OFF_TEST0 |=> $stable(stretch_r) ##1 $stable(page_r))
      else $error("Test register write changed state.");
   AST_SIZE0: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      avs_read_i && avs_address_i == mmc_pkg::OFF_MEMORY_SIZE_0 && bus_req && !avs_waitrequest_o
      |-> avs_readdata_o[7] == reg_sw_s && avs_readdata_o[6] == 1'b0)
      else $error("Size register 0 read wrong.");
   AST_PAGE_RIGHTS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      wr_fire && avs_address_i == mmc_pkg::OFF_PAGE && !page_ok |=> $stable(page_r))
      else $error("Page index written without rights.");
   AST_WAIT_ONE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      bus_req && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("Answer not given in the next cycle.");
   AST_RAM_ALIGN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      align_r && !reset_i ##1 align_r |-> ram_top_o[10:0] == 11'h7ff)
      else $error("High-aligned RAM top not at region end.");

   COV_MISC_WRITE: cover property (@(posedge sys_clk_i) wr_misc);
   COV_PAGE_WRITE: cover property (@(posedge sys_clk_i)
      wr_fire && avs_address_i == mmc_pkg::OFF_PAGE);
   COV_STRETCH:    cover property (@(posedge sys_clk_i) ext_wait_o);
endmodule

// ### verilog/mmc_stretch.sv
`timescale 1ns/1ns
// Holds an external access for the programmed number of extra bus clocks.
module mmc_stretch (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   input  wire logic       ext_req_i,
   input  wire logic [1:0] stretch_i,
   input  wire logic       stretch_en_i,
   output logic            ext_wait_o
);
   logic [1:0] count_r;
   logic       busy_r;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         count_r <= 2'h0;
         busy_r  <= 1'b0;
      end else if (!busy_r && ext_req_i && stretch_en_i && stretch_i != 2'h0) begin
         count_r <= stretch_i;
         busy_r  <= 1'b1;
      end else if (busy_r) begin
         count_r <= count_r - 2'h1;
         busy_r  <= (count_r != 2'h1);
      end
   end

   assign ext_wait_o = busy_r;

   AST_NO_STRETCH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !stretch_en_i && !busy_r |=> !busy_r)
      else $error("Access stretched while stretch is disabled.");
   AST_STRETCH_LEN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !busy_r && ext_req_i && stretch_en_i && stretch_i == 2'h3
      |=> busy_r [*3] ##1 !busy_r)
      else $error("Stretch of three clocks not honoured.");
endmodule
